// ==== serial_register_port_trim_tb_top.sv ====
// Purpose: bench joining host and device ends over one link
// Assumes: byte model of the register space kept by address
// Notes: wdata and read bytes are handled at clock edges by the bench
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module serial_register_port_trim_tb_top;
   import srp_pkg::*;
   localparam logic [15:0] VEN = 16'h5a3c; // arbitrary identity value
   localparam logic [NUM_TERM-1:0] TERM_ON = 4'h7; // last input absent on this variant
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_in = 1'b0;
   logic read_in = 1'b0;
   logic [14:0] addr_in = 15'h0000;
   logic [3:0] extra_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic cal_offset_we_in = 1'b0;
   logic [2:0] cal_offset_slot_in = 3'h0;
   logic [15:0] cal_offset_value_in = 16'h0000;
   logic wdata_take_out, rdata_valid_out, busy_out, done_out;
   logic [7:0] rdata_out;
   logic [NUM_SLOTS-1:0][15:0] core_offset_adjust_out, core_gain_adjust_out;
   logic [15:0] full_scale_adjust_out;
   logic [7:0] bandgap_reference_adjust_out;
   logic [NUM_TERM-1:0][7:0] termination_resistor_adjust_out;
   logic offset_cal_enable_out, background_cal_enable_out;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   int widx = 0;
   logic [7:0] mdl [logic [14:0]];
   logic [7:0] wq [16];
   logic [7:0] rq [$];
   logic [2:0] slot;
   logic [15:0] val;
   srp_link_if srp_link_if_i ();
   srp_device_end #(.INPUT_PRESENT(TERM_ON), .VENDOR_CODE(VEN)) srp_device_end_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(srp_link_if_i),
      .cal_offset_we_in(cal_offset_we_in),
      .cal_offset_slot_in(cal_offset_slot_in), .cal_offset_value_in(cal_offset_value_in),
      .core_offset_adjust_out(core_offset_adjust_out),
      .core_gain_adjust_out(core_gain_adjust_out), .full_scale_adjust_out(full_scale_adjust_out),
      .bandgap_reference_adjust_out(bandgap_reference_adjust_out),
      .termination_resistor_adjust_out(termination_resistor_adjust_out),
      .offset_cal_enable_out(offset_cal_enable_out),
      .background_cal_enable_out(background_cal_enable_out));
   srp_host_end srp_host_end_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .link(srp_link_if_i), .start_in(start_in), .read_in(read_in), .addr_in(addr_in),
      .extra_in(extra_in), .wdata_in(wdata_in), .wdata_take_out(wdata_take_out),
      .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .busy_out(busy_out),
      .done_out(done_out));
   srp_link_monitor srp_link_monitor_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .port_select_n(srp_link_if_i.port_select_n), .sclk(srp_link_if_i.sclk),
      .sdi(srp_link_if_i.sdi), .sdo(srp_link_if_i.sdo), .sdo_oe(srp_link_if_i.sdo_oe));
   // free-running system clock
   always #50 clk_sys_in = ~clk_sys_in;
   // next unit's byte goes up on the edge after the one that consumed the last one
   always @(posedge clk_sys_in) begin
      if (wdata_take_out === 1'b1 && widx < 15) begin
         widx <= widx + 1;
         wdata_in <= #1 wq[widx + 1];
      end
      if (rdata_valid_out === 1'b1)
         rq.push_back(rdata_out);
   end
   // hang guard, well above the longest planned sequence
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // next address of a stream, following the bench copy of the user config
   function automatic logic [14:0] step(input logic [14:0] a, input int i);
      logic [7:0] c;
      c = mdl.exists(ADDR_USER_CFG) ? mdl[ADDR_USER_CFG] : RST_CFG;
      if (c[BIT_ADDR_HOLD])
         return a;
      return c[BIT_STREAM_DIR] ? a - 15'(i) : a + 15'(i);
   endfunction
   function automatic logic [7:0] exp_rd(input logic [14:0] a);
      if (a == ADDR_VENDOR)
         return VEN[7:0];
      if (a == ADDR_VENDOR + 15'h1)
         return VEN[15:8];
      if (mdl.exists(a))
         return mdl[a];
      return (a == ADDR_FS + 15'h1) ? RST_FS[15:8] : 8'h00;
   endfunction
   task automatic fill();
      for (int i = 0; i < 16; i++)
         wq[i] = 8'($urandom);
   endtask
   // one host command of n bytes; writes update the model, reads compare
   task automatic frame(input logic rd, input logic [14:0] a, input int n);
      logic [14:0] ad;
      @(posedge clk_sys_in);
      #1;
      rq.delete();
      widx = 0;
      start_in = 1'b1;
      read_in = rd;
      addr_in = a;
      extra_in = 4'(n - 1);
      wdata_in = wq[0];
      for (int t = 0; t < 3000; t++) begin
         @(posedge clk_sys_in);
         #1;
         start_in = 1'b0;
         if (done_out === 1'b1)
            break;
      end
      `CHK(done_out, 1'b1)
      `CHK(busy_out, 1'b0)
      for (int i = 0; i < n; i++) begin
         ad = step(a, i);
         if (rd)
            `CHK(rq[i], exp_rd(ad))
         else
            mdl[ad] = wq[i];
      end
   endtask
   task automatic cfg(input logic [14:0] a, input logic [7:0] v);
      wq[0] = v;
      frame(1'b0, a, 1);
   endtask
   task automatic cal_pulse(input logic [2:0] s, input logic [15:0] v);
      @(posedge clk_sys_in);
      #1;
      cal_offset_we_in = 1'b1;
      cal_offset_slot_in = s;
      cal_offset_value_in = v;
      @(posedge clk_sys_in);
      #1;
      cal_offset_we_in = 1'b0;
      // applied trims lag the stored bytes by one edge
      @(posedge clk_sys_in);
      #1;
   endtask
   task automatic chk_side();
      logic [7:0] e;
      for (int s = 0; s < NUM_SLOTS; s++)
         `CHK(core_gain_adjust_out[s], {mdl[ADDR_GAIN + 15'(2*s+1)], mdl[ADDR_GAIN + 15'(2*s)]})
      for (int i = 0; i < NUM_TERM; i++) begin
         // an absent input applies zero whatever is stored
         e = TERM_ON[i] ? mdl[ADDR_TERM + 15'(i)] : 8'h00;
         `CHK(termination_resistor_adjust_out[i], e)
      end
   endtask
   initial begin
      void'($urandom(53));
      repeat (10) @(posedge clk_sys_in);
      #1;
      rst_n_in = 1'b1;
      // full scale pair, then read back with vendor and an unmapped place
      fill();
      frame(1'b0, ADDR_FS, 2);
      `CHK(full_scale_adjust_out, {mdl[ADDR_FS + 15'h1], mdl[ADDR_FS]})
      frame(1'b1, ADDR_FS, 2);
      frame(1'b1, ADDR_VENDOR, 2);
      frame(1'b1, 15'h0200, 1);
      // every gain byte in one long stream, read back the same way
      fill();
      frame(1'b0, ADDR_GAIN, 16);
      frame(1'b1, ADDR_GAIN, 16);
      // descending stream over the termination bytes
      cfg(ADDR_USER_CFG, 8'h20);
      fill();
      frame(1'b0, ADDR_TERM + 15'h3, 4);
      chk_side();
      // address hold keeps every unit on one register
      cfg(ADDR_USER_CFG, 8'h01);
      fill();
      frame(1'b0, ADDR_BG, 3);
      `CHK(bandgap_reference_adjust_out, wq[2])
      frame(1'b1, ADDR_BG, 2);
      cfg(ADDR_USER_CFG, 8'h00);
      // calibration writes land only while offset cal is enabled
      slot = 3'($urandom);
      val = 16'($urandom);
      cfg(ADDR_CAL_CFG, 8'h03);
      `CHK(offset_cal_enable_out, 1'b1)
      `CHK(background_cal_enable_out, 1'b1)
      cal_pulse(slot, val);
      `CHK(core_offset_adjust_out[slot], val)
      cfg(ADDR_CAL_CFG, 8'h00);
      cal_pulse(slot ^ 3'h1, ~val);
      `CHK(core_offset_adjust_out[slot ^ 3'h1], RST_OFS)
      chk_side();
      // random single writes among the termination bytes
      repeat (3) begin
         fill();
         frame(1'b0, ADDR_TERM + 15'($urandom_range(3)), 1);
      end
      chk_side();
      complete_run();
   end
endmodule

// ==== srp_device_end.sv ====
// Purpose: serial register port with trim registers of a data converter
// Assumes: sclk, select and sdi are pins, sampled by clk_sys_in
// Notes: sdo changes after sclk falls, so the host samples late in high phase
// Summary of operation
// - host holds select low for whole access
// - input bits captured on rising sclk
// - no timeout, any slow sclk works
// - frame is 24 bits: direction, address, data
// - first bit one reads, zero writes
// - next fifteen bits are register address
// - write stores last eight bits
// - read ignores input, drives register on sdo
// - all fields shifted most significant first
// - wide registers little-endian, low byte first
// - sdo driven only in read data
// - select held low streams further bytes
// - address steps by one, direction configurable
// - address hold stops stepping
// - host avoids access during calibration
// - separate offset trim per converter core
// - gain trims changed only by host writes
// - absent input trims accepted, no effect
// - full scale common, gain trim per converter core
// - host avoids offset writes during offset calibration
`timescale 1ns/1ns
module srp_device_end import srp_pkg::*; #(
   parameter logic [NUM_SLOTS-1:0] SLOT_PRESENT = 8'hff,
   parameter logic [NUM_TERM-1:0] INPUT_PRESENT = 4'hf,
   parameter logic [15:0] VENDOR_CODE = 16'h5a3c // arbitrary value
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   srp_link_if.device link,
   input wire logic cal_offset_we_in,
   input wire logic [2:0] cal_offset_slot_in,
   input wire logic [15:0] cal_offset_value_in,
   output logic [NUM_SLOTS-1:0][15:0] core_offset_adjust_out,
   output logic [NUM_SLOTS-1:0][15:0] core_gain_adjust_out,
   output logic [15:0] full_scale_adjust_out,
   output logic [7:0] bandgap_reference_adjust_out,
   output logic [NUM_TERM-1:0][7:0] termination_resistor_adjust_out,
   output logic offset_cal_enable_out,
   output logic background_cal_enable_out
);
   import srp_pkg::*;

   typedef enum logic [1:0] {
      SRP_HEADER = 2'b01,
      SRP_DATA = 2'b10
   } srp_phase_t;

   logic [2:0] pins_s;
   logic sclk_d;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_n;
   srp_phase_t phase;
   logic [3:0] hdr_cnt;
   logic [2:0] bit_cnt;
   logic [14:0] hdr_sh;
   logic [14:0] addr;
   logic rd_frame;
   logic [6:0] wr_sh;
   logic [7:0] rd_sh;
   logic [7:0] regs [0:NUM_BYTES-1];
   logic hit;
   logic wr_ok;
   logic [5:0] idx;
   logic [7:0] rd_byte;
   logic [14:0] next_addr;

   // sclk, select and sdi arrive from the link domain
   srp_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in({link.sclk, link.port_select_n, link.sdi}),
      .sync_out(pins_s)
   );
   assign sel_n = pins_s[1];

   // edge detect on the synchronised clock
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= pins_s[2];
      end
   end
   assign sclk_rise = pins_s[2] & ~sclk_d & ~sel_n;
   assign sclk_fall = ~pins_s[2] & sclk_d & ~sel_n;

   // map an address onto byte storage; vendor code is read only
   always_comb begin
      hit = 1'b1;
      wr_ok = 1'b1;
      idx = 6'h00;
      if (addr == ADDR_VENDOR || addr == ADDR_VENDOR + 15'h0001) begin
         idx = 6'(IDX_VENDOR) + 6'(addr - ADDR_VENDOR);
         wr_ok = 1'b0;
      end else if (addr == ADDR_USER_CFG) begin
         idx = 6'(IDX_USER_CFG);
      end else if (addr == ADDR_CAL_CFG) begin
         idx = 6'(IDX_CAL_CFG);
      end else if (addr >= ADDR_FS && addr < ADDR_FS + 15'h0002) begin
         idx = 6'(IDX_FS) + 6'(addr - ADDR_FS);
      end else if (addr == ADDR_BG) begin
         idx = 6'(IDX_BG);
      end else if (addr >= ADDR_TERM && addr < ADDR_TERM + 15'(NUM_TERM)) begin
         idx = 6'(IDX_TERM) + 6'(addr - ADDR_TERM);
      end else if (addr >= ADDR_OFS && addr < ADDR_OFS + 15'(2 * NUM_SLOTS)) begin
         idx = 6'(IDX_OFS) + 6'(addr - ADDR_OFS);
      end else if (addr >= ADDR_GAIN && addr < ADDR_GAIN + 15'(2 * NUM_SLOTS)) begin
         idx = 6'(IDX_GAIN) + 6'(addr - ADDR_GAIN);
      end else begin
         hit = 1'b0;
         wr_ok = 1'b0;
      end
   end
   // unmapped addresses read as zero
   assign rd_byte = hit ? regs[idx] : 8'h00;

   // step by one, down when direction bit set
   always_comb begin
      next_addr = addr;
      if (!regs[IDX_USER_CFG][BIT_ADDR_HOLD]) begin
         if (regs[IDX_USER_CFG][BIT_STREAM_DIR]) begin
            next_addr = addr - 15'h0001;
         end else begin
            next_addr = addr + 15'h0001;
         end
      end
   end

   // frame sequencer; advances only on sclk edges, no timer anywhere
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= SRP_HEADER;
         hdr_cnt <= 4'h0;
         bit_cnt <= 3'h0;
         hdr_sh <= 15'h0000;
         addr <= 15'h0000;
         rd_frame <= 1'b0;
         wr_sh <= 7'h00;
      end else if (sel_n) begin
         // select high drops any partial frame
         phase <= SRP_HEADER;
         hdr_cnt <= 4'h0;
         bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
         unique case (phase)
            SRP_HEADER: begin
               // fifteen address bits follow, msb first
               hdr_cnt <= hdr_cnt + 4'h1;
               if (hdr_cnt == 4'h0) begin
                  rd_frame <= pins_s[0];
               end else begin
                  hdr_sh <= {hdr_sh[13:0], pins_s[0]};
               end
               if (hdr_cnt == 4'(HDR_BITS - 1)) begin
                  addr <= {hdr_sh[13:0], pins_s[0]};
                  phase <= SRP_DATA;
                  bit_cnt <= 3'h0;
               end
            end
            SRP_DATA: begin
               // header plus one full byte completes a frame
               // further bytes stream while select is low
               wr_sh <= {wr_sh[5:0], pins_s[0]};
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'(DATA_BITS - 1)) begin
                  addr <= next_addr;
               end
            end
         endcase
      end
   end

   // register storage; host writes then calibration writes to offsets
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            regs[i] <= 8'h00;
         end
         regs[IDX_VENDOR] <= VENDOR_CODE[7:0];
         regs[IDX_VENDOR + 1] <= VENDOR_CODE[15:8];
         regs[IDX_USER_CFG] <= RST_CFG;
         regs[IDX_CAL_CFG] <= RST_CFG;
         regs[IDX_FS] <= RST_FS[7:0];
         regs[IDX_FS + 1] <= RST_FS[15:8];
         regs[IDX_BG] <= RST_BG;
         for (int i = 0; i < NUM_TERM; i++) begin
            regs[IDX_TERM + i] <= RST_TERM;
         end
         for (int i = 0; i < NUM_SLOTS; i++) begin
            regs[IDX_OFS + 2 * i] <= RST_OFS[7:0];
            regs[IDX_OFS + 2 * i + 1] <= RST_OFS[15:8];
            regs[IDX_GAIN + 2 * i] <= RST_GAIN[7:0];
            regs[IDX_GAIN + 2 * i + 1] <= RST_GAIN[15:8];
         end
      end else begin
         // commit byte on its eighth rising edge; absent ones too
         if (sclk_rise && phase == SRP_DATA && bit_cnt == 3'(DATA_BITS - 1) &&
               !rd_frame && wr_ok) begin
            regs[idx] <= {wr_sh, pins_s[0]};
         end
         // offsets may be refreshed per core by calibration
         // calibration has no path into gain bytes
         if (cal_offset_we_in && regs[IDX_CAL_CFG][BIT_OFS_CAL]) begin
            regs[IDX_OFS + 2 * cal_offset_slot_in] <= cal_offset_value_in[7:0];
            regs[IDX_OFS + 2 * cal_offset_slot_in + 1] <= cal_offset_value_in[15:8];
         end
      end
   end

   // read data driven on falling edges, input ignored
   // enable only in data portion of read frames
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         link.sdo <= 1'b0;
         link.sdo_oe <= 1'b0;
         rd_sh <= 8'h00;
      end else if (sel_n) begin
         link.sdo_oe <= 1'b0;
      end else if (sclk_fall && phase == SRP_DATA) begin
         link.sdo_oe <= rd_frame;
         if (bit_cnt == 3'h0) begin
            link.sdo <= rd_byte[7];
            rd_sh <= {rd_byte[6:0], 1'b0};
         end else begin
            link.sdo <= rd_sh[7];
            rd_sh <= {rd_sh[6:0], 1'b0};
         end
      end
   end

   // applied trims; low byte at lower address
   // slots and inputs absent on this variant apply zero
   // one full-scale value for every input
   generate
      for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
         always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               core_offset_adjust_out[g] <= RST_OFS;
               core_gain_adjust_out[g] <= RST_GAIN;
            end else begin
               core_offset_adjust_out[g] <= SLOT_PRESENT[g] ?
                  {regs[IDX_OFS + 2 * g + 1], regs[IDX_OFS + 2 * g]} : 16'h0000;
               core_gain_adjust_out[g] <= SLOT_PRESENT[g] ?
                  {regs[IDX_GAIN + 2 * g + 1], regs[IDX_GAIN + 2 * g]} : 16'h0000;
            end
         end
      end
      for (genvar g = 0; g < NUM_TERM; g++) begin : g_term
         always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               termination_resistor_adjust_out[g] <= RST_TERM;
            end else begin
               termination_resistor_adjust_out[g] <= INPUT_PRESENT[g] ?
                  regs[IDX_TERM + g] : 8'h00;
            end
         end
      end
   endgenerate

   // common settings
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         full_scale_adjust_out <= RST_FS;
         bandgap_reference_adjust_out <= RST_BG;
         offset_cal_enable_out <= 1'b0;
         background_cal_enable_out <= 1'b0;
      end else begin
         full_scale_adjust_out <= {regs[IDX_FS + 1], regs[IDX_FS]};
         bandgap_reference_adjust_out <= regs[IDX_BG];
         offset_cal_enable_out <= regs[IDX_CAL_CFG][BIT_OFS_CAL];
         background_cal_enable_out <= regs[IDX_CAL_CFG][BIT_BG_CAL];
      end
   end
endmodule

// ==== srp_host_end.sv ====
// Purpose: serial master issuing single or streaming register frames
// Assumes: sclk made here by a divider of clk_sys_in
// Notes: sdo sampled in the last cycle of the high phase, past sync delay
`timescale 1ns/1ns
module srp_host_end import srp_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   srp_link_if.host link,
   input wire logic start_in,
   input wire logic read_in,
   input wire logic [14:0] addr_in,
   input wire logic [3:0] extra_in,
   input wire logic [7:0] wdata_in,
   output logic wdata_take_out,
   output logic [7:0] rdata_out,
   output logic rdata_valid_out,
   output logic busy_out,
   output logic done_out
);
   import srp_pkg::*;

   typedef enum logic [3:0] {
      SRP_IDLE = 4'b0001,
      SRP_LEAD = 4'b0010,
      SRP_RUN = 4'b0100,
      SRP_TAIL = 4'b1000
   } srp_hstate_t;

   srp_hstate_t state;
   logic [2:0] div;
   logic [7:0] bitn;
   logic [7:0] total;
   logic [23:0] tx;
   logic [7:0] rx;
   logic sdo_s;
   logic div_end;
   logic unit_end;
   logic rd_mode;

   srp_sync #(.WIDTH(1), .INIT(1'b0)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in(link.sdo),
      .sync_out(sdo_s)
   );

   assign div_end = div == 3'(SCLK_HALF_CYC - 1);
   // a byte finishes at bit 24 and every eight after
   assign unit_end = bitn >= 8'(FRAME_BITS) && bitn[2:0] == 3'h0;

   // half-period divider
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div <= 3'h0;
      end else if (state == SRP_IDLE || div_end) begin
         div <= 3'h0;
      end else begin
         div <= div + 3'h1;
      end
   end

   // frame sequencer; select low across the whole frame
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= SRP_IDLE;
         link.port_select_n <= 1'b1;
         link.sclk <= 1'b0;
         link.sdi <= 1'b0;
         bitn <= 8'h00;
         total <= 8'h00;
         tx <= 24'h000000;
         rx <= 8'h00;
         wdata_take_out <= 1'b0;
         rdata_out <= 8'h00;
         rdata_valid_out <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         wdata_take_out <= 1'b0;
         rdata_valid_out <= 1'b0;
         done_out <= 1'b0;
         unique case (state)
            SRP_IDLE: begin
               // caller keeps frames away from calibration
               if (start_in) begin
                  tx <= {read_in, addr_in, read_in ? 8'h00 : wdata_in};
                  link.sdi <= read_in;
                  total <= 8'(FRAME_BITS) + {1'b0, extra_in, 3'h0};
                  bitn <= 8'h00;
                  wdata_take_out <= ~read_in;
                  link.port_select_n <= 1'b0;
                  busy_out <= 1'b1;
                  state <= SRP_LEAD;
               end
            end
            SRP_LEAD: begin
               if (div_end) begin
                  state <= SRP_RUN;
               end
            end
            SRP_RUN: begin
               if (div_end && !link.sclk) begin
                  link.sclk <= 1'b1;
                  bitn <= bitn + 8'h01;
               end else if (div_end) begin
                  link.sclk <= 1'b0;
                  if (bitn > 8'(HDR_BITS)) begin
                     rx <= {rx[6:0], sdo_s};
                  end
                  // tx has long shifted out its direction bit, so the latched one decides
                  if (unit_end && rd_mode) begin
                     rdata_out <= {rx[6:0], sdo_s};
                  end
                  rdata_valid_out <= unit_end & rd_mode;
                  if (bitn == total) begin
                     state <= SRP_TAIL;
                  end else if (unit_end) begin
                     tx <= {wdata_in, 16'h0000};
                     link.sdi <= wdata_in[7];
                     wdata_take_out <= ~rd_mode;
                  end else begin
                     tx <= {tx[22:0], 1'b0};
                     link.sdi <= tx[22];
                  end
               end
            end
            SRP_TAIL: begin
               if (div_end) begin
                  link.port_select_n <= 1'b1;
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  state <= SRP_IDLE;
               end
            end
         endcase
      end
   end

   // direction of the running frame
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_mode <= 1'b0;
      end else if (state == SRP_IDLE && start_in) begin
         rd_mode <= read_in;
      end
   end
endmodule

// ==== srp_link_if.sv ====
// Purpose: four-wire serial link between host and register port
// Assumes: device drives sdo at all times; host reads it directly, sdo_oe only feeds the monitor
// Notes: no clocking block, plain wires
`timescale 1ns/1ns
interface srp_link_if;
   logic port_select_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   modport device (input port_select_n, input sclk, input sdi, output sdo, output sdo_oe);
   modport host (output port_select_n, output sclk, output sdi, input sdo, input sdo_oe);
endinterface

// ==== srp_link_monitor.sv ====
// Purpose: link-level checks between host and device ends
// Assumes: host drives sclk from a register of clk_sys_in
// Notes: sdo_oe lags sclk by the device synchroniser delay
`timescale 1ns/1ns
module srp_link_monitor (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic port_select_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic [7:0] bit_cnt;
   logic sclk_q;
   logic rd_frame;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // count rising serial clock edges within one select window
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bit_cnt <= 8'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
         if (port_select_n)
            bit_cnt <= 8'h00;
         else if (sclk && !sclk_q)
            bit_cnt <= bit_cnt + 8'h01;
      end
   end
   // direction bit is latched at the first rise, kept until the next frame
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rd_frame <= 1'b0;
      else if (!port_select_n && sclk && !sclk_q && bit_cnt == 8'h00)
         rd_frame <= sdi;
   end
   frame_length_a: assert property ($rose(port_select_n) |->
      bit_cnt >= 8'h18 && bit_cnt[2:0] == 3'h0) else $error("frame length wrong");
   header_quiet_a: assert property (!port_select_n && bit_cnt != 8'h00 &&
      bit_cnt < 8'h10 |-> !sdo_oe) else $error("sdo driven in header");
   write_quiet_a: assert property (!rd_frame && bit_cnt > 8'h01 |-> !sdo_oe)
      else $error("sdo driven in write frame");
   read_drive_a: assert property ($rose(sclk) && rd_frame && bit_cnt >= 8'h10 |-> sdo_oe)
      else $error("sdo not driven in read data");
   clock_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("sclk high phase wrong");
   idle_clock_a: assert property (port_select_n |-> !sclk)
      else $error("sclk active while deselected");
   sdi_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("sdi moved while sclk high");
   sdo_hold_a: assert property (sdo_oe && $past(sdo_oe) && sclk |-> $stable(sdo))
      else $error("sdo moved while sclk high");
endmodule

// ==== srp_pkg.sv ====
// Purpose: shared constants for the serial register port and its host
// Assumes: one byte per register address, 15-bit address space
// Notes: sclk timing derived from the system clock rate
package srp_pkg;
   localparam int FRAME_BITS = 24;
   localparam int HDR_BITS = 16;
   localparam int ADDR_BITS = 15;
   localparam int DATA_BITS = 8;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int NUM_SLOTS = 8;
   localparam int NUM_TERM = 4;
   // address map
   localparam logic [14:0] ADDR_VENDOR = 15'h000c;
   localparam logic [14:0] ADDR_USER_CFG = 15'h0010;
   localparam logic [14:0] ADDR_FS = 15'h0030;
   localparam logic [14:0] ADDR_CAL_CFG = 15'h0062;
   localparam logic [14:0] ADDR_BG = 15'h007c;
   localparam logic [14:0] ADDR_TERM = 15'h007e;
   localparam logic [14:0] ADDR_OFS = 15'h0330;
   localparam logic [14:0] ADDR_GAIN = 15'h0350;
   // byte storage indices
   localparam int IDX_VENDOR = 0;
   localparam int IDX_USER_CFG = 2;
   localparam int IDX_CAL_CFG = 3;
   localparam int IDX_FS = 4;
   localparam int IDX_BG = 6;
   localparam int IDX_TERM = 7;
   localparam int IDX_OFS = 11;
   localparam int IDX_GAIN = 27;
   localparam int NUM_BYTES = 43;
   // field positions
   localparam int BIT_ADDR_HOLD = 0;
   localparam int BIT_STREAM_DIR = 5;
   localparam int BIT_OFS_CAL = 0;
   localparam int BIT_BG_CAL = 1;
   // reset values
   localparam logic [15:0] RST_FS = 16'ha000;
   localparam logic [7:0] RST_BG = 8'h00;
   localparam logic [7:0] RST_TERM = 8'h00;
   localparam logic [15:0] RST_OFS = 16'h0000;
   localparam logic [15:0] RST_GAIN = 16'h0000;
   localparam logic [7:0] RST_CFG = 8'h00;
endpackage

// ==== srp_sync.sv ====
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module srp_sync #(parameter int WIDTH = 1, parameter logic [WIDTH-1:0] INIT = '0) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;
   // two stages against metastability
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= INIT;
         sync_out <= INIT;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
